//--- ehpt_pkg.sv
// Constants, register map and types of the interval/PWM timer
package ehpt_pkg;
  localparam int ADDR_W = 18;
  localparam int PRE_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PORT_LATCH = 16'hFF01;
  localparam logic [15:0] IDX_PERIOD = 16'hFF10;
  localparam logic [15:0] IDX_WIDTH = 16'hFF11;
  localparam logic [15:0] IDX_COUNT = 16'hFF12;
  localparam logic [15:0] IDX_PORT_DIR = 16'hFF21;
  localparam logic [15:0] IDX_MODE = 16'hFF6C;
  localparam logic [15:0] IDX_CARRIER = 16'hFF6D;
  // Values after reset
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CARRIER = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic [7:0] RST_PORT_LATCH = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  // Mode register fields
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_CKS_LSB = 4;
  localparam int MODE_MD_LSB = 2;
  localparam int MODE_TOLEV_BIT = 1;
  localparam int MODE_TOEN_BIT = 0;
  // Carrier control fields
  localparam int CAR_RMC_BIT = 2;
  localparam int CAR_NRZB_BIT = 1;
  localparam int CAR_NRZ_BIT = 0;
  // Port bit that carries the timer output
  localparam int TIMER_PIN_BIT = 6;
  // Count clocks a new width value must age before transfer
  localparam logic [1:0] WIDTH_XFER_TICKS = 2'h3;
  // Prescaler shift per count clock select code, code 7 first
  localparam logic [7:0][3:0] CKS_SHIFT = {4'h0, 4'h9, 4'h7, 4'hC, 4'h6, 4'h4, 4'h2, 4'h0};
  typedef enum logic [1:0] {
    MD_INTERVAL = 2'h0,
    MD_CARRIER = 2'h1,
    MD_PWM = 2'h2,
    MD_PROHIBITED = 2'h3
  } ehpt_mode_type;
  typedef enum logic [1:0] {
    PH_PERIOD = 2'b01,
    PH_WIDTH = 2'b10
  } ehpt_phase_type;
endpackage

//--- ehpt_tick_if.sv
// Count clock select and tick between top and prescaler
`timescale 1ns/100ps
interface ehpt_tick_if;
  logic [2:0] sel;
  logic tick;
  modport src (input sel, output tick);
  modport sink (output sel, input tick);
endinterface

//--- ehpt_prescale.sv
// Count clock prescaler: one-cycle tick at the selected rate
`timescale 1ns/100ps
module ehpt_prescale
  import ehpt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  ehpt_tick_if.src tk
);
  logic [PRE_W-1:0] pre_ff;
  wire [PRE_W-1:0] nxt_pre = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
  wire [3:0] shift = CKS_SHIFT[tk.sel];
  wire [PRE_W-1:0] mask = PRE_W'((PRE_W+1)'(1) << shift) - {{(PRE_W-1){1'b0}}, 1'b1};
  assign tk.tick = ce && ((pre_ff & mask) == mask);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_ff <= '0;
    end else if (ce) begin
      pre_ff <= nxt_pre;
    end
  end
endmodule

//--- ehpt_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module ehpt_sync #(
  parameter int W = 9
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else if (ce) begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end
endmodule

//--- ehpt_timer.sv
// Eight-bit interval/PWM/carrier timer with Avalon-MM register slave
//
// What this block does
// - Remote output: mode0 gives level bit, mode1 gives carrier when level set.
// - Carrier control bit 0 is a read-only status flag.
// - Direction bit 0 drives the pin, 1 releases it as input.
// - Interval mode: period match pulses interrupt and clears counter to 00H.
// - Interval mode ignores the width compare register entirely.
// - Interval mode with output enabled toggles output each match, 50% duty.
// - Counting begins no later than two count clocks after enable; the first count clock is masked.
// - Clearing count enable forces interrupt and output inactive, except carrier mode with RMC 0, where the pin follows the NRZ level.
// - PWM: period and width may both be rewritten while counting; a period write takes effect at once.
// - PWM: period match clears, interrupts, activates; width match deactivates only.
// - PWM period is period value plus one, width is width value plus one.
// - New width value needs three count clocks before transfer.
// - PWM start masks the first count clock; output inactive until first match.
// - Mode field: 00 interval, 01 carrier, 10 PWM, 11 prohibited.
// - Count enable 0 stops and holds counter at zero.
// - Outside carrier mode, output level bit sets inactive level; active level is its opposite.
`timescale 1ns/100ps
module ehpt_timer
  import ehpt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ehpt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] port1_in,
  input wire logic carrier_pace_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe_n,
  output logic compare_match_interrupt
);
  import ehpt_pkg::*;

  ehpt_tick_if tk ();

  logic wait_ff;
  logic [7:0] rdata_ff;
  logic [7:0] mode_ff;
  logic [7:0] period_ff;
  logic [7:0] width_wr_ff;
  logic [7:0] width_act_ff;
  logic width_pend_ff;
  logic [1:0] width_age_ff;
  logic [7:0] cnt_ff;
  ehpt_phase_type phase_ff;
  logic mask_ff;
  logic tstate_ff;
  logic int_ff;
  logic rmc_ff;
  logic nrzb_ff;
  logic nrz_ff;
  logic pace_q_ff;
  logic pace_req_ff;
  logic pace_s1_ff;
  logic pace_s2_ff;
  logic [7:0] dir_ff;
  logic [7:0] latch_ff;
  logic [7:0] pout_ff;
  logic [7:0] poe_n_ff;
  logic [8:0] sync_q;

  ehpt_sync #(
    .W(9)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d_in({carrier_pace_in, port1_in}),
    .q_ff(sync_q)
  );

  ehpt_prescale u_pre (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .tk(tk)
  );

  // Mode register fields
  wire en = mode_ff[MODE_EN_BIT];
  wire tolev = mode_ff[MODE_TOLEV_BIT];
  wire toen = mode_ff[MODE_TOEN_BIT];
  wire [1:0] md = mode_ff[MODE_MD_LSB +: 2];
  wire is_pwm = (md == MD_PWM);
  wire is_car = (md == MD_CARRIER);
  assign tk.sel = mode_ff[MODE_CKS_LSB +: 3];

  // Bus decode
  wire [15:0] idx = avs_address[ADDR_W-1:2];
  wire bus_req = avs_read || avs_write;
  wire nxt_wait = !(bus_req && wait_ff);
  wire wr_go = avs_write && !wait_ff && avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_mode = wr_go && (idx == IDX_MODE);
  wire wr_period = wr_go && (idx == IDX_PERIOD);
  wire wr_width = wr_go && (idx == IDX_WIDTH);
  wire wr_car = wr_go && (idx == IDX_CARRIER);
  wire wr_dir = wr_go && (idx == IDX_PORT_DIR);
  wire wr_latch = wr_go && (idx == IDX_PORT_LATCH);
  // Only count enable may change while running
  wire [7:0] nxt_mode = en ? {wd[MODE_EN_BIT], mode_ff[6:0]} : wd;
  // A stopping write blocks any match on its own edge
  wire stop_now = wr_mode && !wd[MODE_EN_BIT];

  // Compare and count
  wire run_tick = tk.tick && en && !stop_now;
  wire counting = run_tick && !mask_ff;
  wire [7:0] target = (phase_ff == PH_WIDTH) ? width_act_ff : period_ff;
  wire match = (cnt_ff == target);
  wire hit_period = counting && match && (phase_ff == PH_PERIOD);
  wire hit_width = counting && match && (phase_ff == PH_WIDTH);
  wire clr_cnt = hit_period || (hit_width && is_car);
  wire [7:0] nxt_cnt = clr_cnt ? 8'h00 : cnt_ff + 8'h01;
  wire width_xfer = width_pend_ff && (width_age_ff == WIDTH_XFER_TICKS) && (hit_period || hit_width);

  // Carrier pacing
  wire pace_rise = sync_q[8] && !pace_q_ff;
  wire nxt_pace_req = pace_rise || (pace_req_ff && !tk.tick);
  wire nrz_xfer = tk.tick && pace_s2_ff && is_car;

  // Output level
  wire remote = rmc_ff ? (nrz_ff && tstate_ff) : nrz_ff;
  wire timer_lvl = is_car ? remote : (tstate_ff ^ tolev);
  wire pin_lvl = toen ? timer_lvl : tolev;

  wire [7:0] nxt_pout;
  wire [7:0] port_rd;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign nxt_pout[gi] = latch_ff[gi] | ((gi == TIMER_PIN_BIT) ? pin_lvl : 1'b0);
      assign port_rd[gi] = dir_ff[gi] ? sync_q[gi] : latch_ff[gi];
    end
  endgenerate

  wire [7:0] car_rd = {5'h00, rmc_ff, nrzb_ff, nrz_ff};
  wire [7:0] rd_val = (idx == IDX_MODE) ? mode_ff :
                      (idx == IDX_PERIOD) ? period_ff :
                      (idx == IDX_WIDTH) ? width_wr_ff :
                      (idx == IDX_COUNT) ? cnt_ff :
                      (idx == IDX_CARRIER) ? car_rd :
                      (idx == IDX_PORT_DIR) ? dir_ff :
                      (idx == IDX_PORT_LATCH) ? port_rd : 8'h00;

  // Bus slave
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      wait_ff <= nxt_wait;
      rdata_ff <= rd_val;
    end
  end

  // Software registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_ff <= RST_MODE;
      period_ff <= RST_COMPARE;
      dir_ff <= RST_PORT_DIR;
      latch_ff <= RST_PORT_LATCH;
      rmc_ff <= RST_CARRIER[CAR_RMC_BIT];
      nrzb_ff <= RST_CARRIER[CAR_NRZB_BIT];
    end else if (ce) begin
      if (wr_mode) mode_ff <= nxt_mode;
      if (wr_period) period_ff <= wd;
      if (wr_dir) dir_ff <= wd;
      if (wr_latch) latch_ff <= wd;
      if (wr_car) begin
        rmc_ff <= wd[CAR_RMC_BIT];
        nrzb_ff <= wd[CAR_NRZB_BIT];
      end
    end
  end

  // Width staging; a write always restarts the age count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      width_wr_ff <= RST_COMPARE;
      width_act_ff <= RST_COMPARE;
      width_pend_ff <= 1'b0;
      width_age_ff <= 2'h0;
    end else if (ce) begin
      if (width_xfer) width_act_ff <= width_wr_ff;
      if (wr_width) begin
        width_wr_ff <= wd;
        width_pend_ff <= 1'b1;
        width_age_ff <= 2'h0;
      end else if (width_xfer) begin
        width_pend_ff <= 1'b0;
      end else if (wr_mode && en && !wd[MODE_EN_BIT]) begin
        width_pend_ff <= 1'b0;
      end else if (tk.tick && width_pend_ff && width_age_ff != WIDTH_XFER_TICKS) begin
        width_age_ff <= width_age_ff + 2'h1;
      end
    end
  end

  // Counter, compare phase and output state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      phase_ff <= PH_PERIOD;
      mask_ff <= 1'b1;
      tstate_ff <= 1'b0;
      int_ff <= 1'b0;
    end else if (ce) begin
      int_ff <= clr_cnt;
      if (!en) begin
        cnt_ff <= 8'h00;
        phase_ff <= PH_PERIOD;
        mask_ff <= 1'b1;
        tstate_ff <= 1'b0;
      end else begin
        if (run_tick) mask_ff <= 1'b0;
        if (counting) cnt_ff <= nxt_cnt;
        if (hit_period) begin
          tstate_ff <= (is_pwm || is_car) ? 1'b1 : !tstate_ff;
          if (is_pwm || is_car) phase_ff <= PH_WIDTH;
        end else if (hit_width) begin
          tstate_ff <= 1'b0;
          phase_ff <= PH_PERIOD;
        end
      end
    end
  end

  // Carrier status transfer and pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pace_q_ff <= 1'b0;
      pace_req_ff <= 1'b0;
      pace_s1_ff <= 1'b0;
      pace_s2_ff <= 1'b0;
      nrz_ff <= RST_CARRIER[CAR_NRZ_BIT];
      pout_ff <= 8'h00;
      poe_n_ff <= RST_PORT_DIR;
    end else if (ce) begin
      pace_q_ff <= sync_q[8];
      pace_req_ff <= nxt_pace_req;
      if (tk.tick) begin
        pace_s1_ff <= pace_req_ff;
        pace_s2_ff <= pace_s1_ff;
      end
      if (nrz_xfer) nrz_ff <= nrzb_ff;
      pout_ff <= nxt_pout;
      poe_n_ff <= dir_ff;
    end
  end

  assign avs_readdata = {24'h000000, rdata_ff};
  assign avs_waitrequest = wait_ff;
  assign port1_out = pout_ff;
  assign port1_oe_n = poe_n_ff;
  assign compare_match_interrupt = int_ff;

  chk_stop_holds_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !en) |=> (cnt_ff == 8'h00))
    else $error("counter not held at zero while stopped");
  chk_stop_inactive: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !en) |=> (!compare_match_interrupt && !tstate_ff))
    else $error("interrupt or output active while stopped");
  chk_interval_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && counting && match && md == MD_INTERVAL) |=> (compare_match_interrupt && cnt_ff == 8'h00))
    else $error("interval match did not clear and interrupt");
  chk_interval_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && hit_period && md == MD_INTERVAL) |=> (tstate_ff != $past(tstate_ff)))
    else $error("interval match did not toggle output");
  chk_interval_no_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    (md == MD_INTERVAL && en) |-> (phase_ff == PH_PERIOD))
    else $error("width compare used in interval mode");
  chk_pwm_width_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && hit_width && is_pwm) |=> (!tstate_ff && !compare_match_interrupt && cnt_ff == $past(cnt_ff) + 8'h01))
    else $error("width match misbehaved in PWM mode");
  chk_first_tick_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && run_tick && mask_ff) |=> (!mask_ff && cnt_ff == 8'h00 && !tstate_ff))
    else $error("first count clock not masked");
  chk_width_age: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && width_xfer && !wr_width) |=> (width_act_ff == $past(width_wr_ff) && width_age_ff == 2'h3))
    else $error("width transferred before three count clocks");
  chk_status_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && wr_car && !nrz_xfer) |=> (nrz_ff == $past(nrz_ff)))
    else $error("status flag changed by a bus write");
  chk_dir_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce |=> (port1_oe_n == $past(dir_ff)))
    else $error("pin enable does not follow direction register");
  chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && bus_req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

//--- ehpt_load.sv
// Far-side model: port pins with pull-ups and the external pacing counter
`timescale 1ns/100ps
module ehpt_load (
  input wire logic core_clk,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe_n,
  input wire logic pace_go,
  output logic [7:0] pin,
  output logic carrier_pace_in
);
  int hold;
  // Released pins float up to the pull-up level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = port1_oe_n[i] ? 1'b1 : port1_out[i];
    end
  end
  initial begin
    carrier_pace_in = 1'b0;
    hold = 0;
  end
  // One slow pacing pulse, far below a sixth of the count clock rate
  always @(posedge core_clk) begin
    if (pace_go && hold == 0) begin
      carrier_pace_in <= 1'b1;
      hold <= 16;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 9) begin
        carrier_pace_in <= 1'b0;
      end
    end
  end
endmodule

//--- eight_bit_interval_pwm_timer_tb.sv
// Testbench of the interval/PWM timer through its register bus
`timescale 1ns/100ps
module eight_bit_interval_pwm_timer_tb;
  import ehpt_pkg::*;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, compare_match_interrupt;
  logic pace_go, carrier_pace_in;
  logic [ehpt_pkg::ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] port1_out, port1_oe_n, pin;
  int bad_count, checks_done, t, h, p;
  logic [7:0] pn [3] = '{8'h05, 8'hFF, 8'h01};
  logic [7:0] wn [3] = '{8'h01, 8'hFE, 8'h00};

  ehpt_timer dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port1_in(pin),
    .carrier_pace_in(carrier_pace_in), .port1_out(port1_out), .port1_oe_n(port1_oe_n),
    .compare_match_interrupt(compare_match_interrupt));
  ehpt_load load_u (.core_clk(core_clk), .port1_out(port1_out), .port1_oe_n(port1_oe_n),
    .pace_go(pace_go), .pin(pin), .carrier_pace_in(carrier_pace_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(x, {24'h0, exp});
  endtask

  // Wait for an interrupt, then count cycles and pin-high cycles over k intervals
  task automatic meas(input int k, output int tot, output int hi, output int pre);
    int n;
    n = 0;
    tot = 0;
    hi = 0;
    pre = 0;
    do begin
      @(negedge core_clk);
      n++;
      if (compare_match_interrupt !== 1'b1) pre += (pin[6] === 1'b1);
    end while (compare_match_interrupt !== 1'b1 && n < 3000);
    repeat (k) begin
      do begin
        @(negedge core_clk);
        tot++;
        hi += (pin[6] === 1'b1);
      end while (compare_match_interrupt !== 1'b1 && tot < 3000);
    end
    if (n >= 3000 || tot >= 3000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // No interrupt over six cycles after a stop, then the given pin level at their end
  task automatic idle_chk(input logic lvl);
    int n;
    n = 0;
    repeat (6) begin
      @(negedge core_clk);
      n += (compare_match_interrupt === 1'b1);
    end
    chk(n, 0);
    chk({31'h0, pin[6]}, {31'h0, lvl});
  endtask

  task automatic pace();
    @(posedge core_clk);
    pace_go <= 1'b1;
    @(posedge core_clk);
    pace_go <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = 32'h0;
    pace_go = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(IDX_PORT_DIR, 8'hFF);
    rdchk(IDX_CARRIER, 8'h00);
    rdchk(IDX_MODE, 8'h00);
    rdchk(IDX_PORT_LATCH, 8'hFF);
    rdchk(16'h0000, 8'h00);
    wr(IDX_CARRIER, 8'h07);
    rdchk(IDX_CARRIER, 8'h06);
    wr(IDX_PORT_LATCH, 8'h00);
    wr(IDX_PORT_DIR, 8'hBF);
    idle_chk(1'b0);
    chk({24'h0, port1_oe_n}, 32'hBF);
    // Carrier mode: status follows buffered level on pacing events
    wr(IDX_PERIOD, 8'h02);
    wr(IDX_MODE, 8'h05);
    wr(IDX_WIDTH, 8'h01);
    wr(IDX_MODE, 8'h85);
    wr(IDX_CARRIER, 8'h02);
    pace();
    rdchk(IDX_CARRIER, 8'h03);
    meas(2, t, h, p);
    chk(h, t);
    wr(IDX_CARRIER, 8'h06);
    meas(2, t, h, p);
    chk(t, 5);
    chk({31'h0, h > 0 && h < t}, 32'h1);
    wr(IDX_CARRIER, 8'h04);
    pace();
    rdchk(IDX_CARRIER, 8'h04);
    meas(2, t, h, p);
    chk(h, 0);
    wr(IDX_MODE, 8'h05);
    // Interval mode with square wave, width register set but unused
    wr(IDX_PERIOD, 8'h03);
    wr(IDX_WIDTH, 8'h01);
    wr(IDX_MODE, 8'h01);
    wr(IDX_MODE, 8'h81);
    meas(2, t, h, p);
    chk(t, 8);
    chk(h, 4);
    wr(IDX_MODE, 8'h01);
    idle_chk(1'b0);
    rdchk(IDX_COUNT, 8'h00);
    wr(IDX_MODE, 8'h11);
    wr(IDX_MODE, 8'h91);
    meas(1, t, h, p);
    chk(t, 16);
    wr(IDX_MODE, 8'h11);
    wr(IDX_MODE, 8'h00);
    wr(IDX_MODE, 8'h80);
    meas(2, t, h, p);
    chk(t, 8);
    chk(h, 0);
    // PWM at several period and width values, boundaries included
    wr(IDX_MODE, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_MODE, 8'h09);
      wr(IDX_PERIOD, pn[i]);
      wr(IDX_WIDTH, wn[i]);
      wr(IDX_MODE, 8'h89);
      meas(1, t, h, p);
      chk(p, 0);
      chk(t, pn[i] + 1);
      chk(h, wn[i] + 1);
    end
    wr(IDX_MODE, 8'h09);
    wr(IDX_PERIOD, 8'h05);
    wr(IDX_WIDTH, 8'h01);
    wr(IDX_MODE, 8'h89);
    meas(1, t, h, p);
    wr(IDX_WIDTH, 8'h03);
    meas(2, t, h, p);
    meas(1, t, h, p);
    chk(t, 6);
    chk(h, 4);
    wr(IDX_MODE, 8'h09);
    idle_chk(1'b0);
    wr(IDX_MODE, 8'h0B);
    idle_chk(1'b1);
    wr(IDX_WIDTH, 8'h01);
    wr(IDX_MODE, 8'h8B);
    meas(1, t, h, p);
    chk(t, 6);
    chk(h, 4);
    wr(IDX_MODE, 8'h0B);
    idle_chk(1'b1);
    tally_and_finish();
  end
endmodule
